// [lci_host_model.sv]
// host master model on the register strobe port of the link control core
// assumes callers run in the clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module lci_host_model (
  input wire logic clk_sys,
  output var lci_pkg::lci_bus_type bus,
  input wire logic [31:0] rdData
);
  initial bus = '0;
  // ********************
  // bus cycles
  // ********************
  // whole quadlet write
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus.addr <= a;
    bus.wrData <= d;
    bus.wr <= 1'b1;
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    bus.addr <= ~a;
    bus.wrData <= ~d;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    bus.addr <= ~a;
    #1 d = rdData;
  endtask : rd
  task automatic poll(output logic [31:0] pwr, output logic [31:0] sum);
    rd(12'h0B0, pwr);
    rd(12'h0BC, sum);
  endtask : poll
endmodule : lci_host_model
`default_nettype wire

// [lci_link_ctrl.sv]
// link control core: transmit confirmations, interrupt gathering, node id and link control
// assumes a host on a plain strobe port and transmitter/PHY logic on clk_sys
// Functional notes
// - build a confirmation entry after every sent request, response or stream packet
// - request confirmations go to request queue, response ones to response queue
// - confirmation carries the packet's label; host keeps active labels unique
// - codes 0 none, 1 complete/broadcast, 2 pending, 4 retry, D data, E type
// - one host interrupt output ORs enabled status from five areas
// - each status bit has its own enable gating the interrupt
// - summary low nibble shows per-area OR of enabled status, not latched
// - writing one clears a status bit; writing zero leaves it
// - status bits latch until acknowledged
// - in power-down only power-domain status reads true; others read filler
// - registers are whole 32-bit quadlets; undefined bits ignore writes
// - node number loads from PHY when bus reset completes
// - bus number returns to 0x3FF on every bus reset
// - bus and node number form source address and packet filter
// - read-only part code and revision code in node identity
// - identity-valid bit enables acceptance; set after self-id, in the same cycle as node update
// - bit 30 routes self-id and PHY packets to request queue
// - bits 29..27 choose the busy policy
// - bit 26 enables the transmitter
// - bit 25 enables the receiver
// - bit 23 picks data-invariant order, only in little-endian mode
// - bit 22 holds endian strap caught during reset
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "lci_map.svh"
module lci_link_ctrl #(
  parameter logic [7:0] PART_CODE = 8'hA5, // arbitrary value
  parameter logic [7:0] REV_CODE = 8'h5A // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire lci_pkg::lci_bus_type bus,
  output logic [31:0] rdData,
  input wire lci_pkg::lci_tx_type tx,
  output logic confValid,
  output lci_pkg::lci_conf_type conf,
  input wire logic [4:0][7:0] areaEvent,
  input wire logic busResetStart,
  input wire logic busResetDone,
  input wire logic [5:0] phyNodeNumber,
  input wire logic linkPowerDownPin,
  input wire logic littleEndianStrapPin,
  output logic host_interrupt_n,
  output logic [15:0] sourceAddress,
  output logic identityValid,
  output logic selfIdReceive,
  output logic [2:0] busyPolicy,
  output logic transmitEnable,
  output logic receiveEnable,
  output logic littleEndian,
  output logic byteOrderInvariance
);
  // ********************
  // helpers
  // ********************
  function automatic logic [3:0] confCode(input lci_pkg::lci_tx_type t);
    logic [3:0] c;
    c = `LCI_CONF_NOACK;
    if (t.broadcast) begin
      c = `LCI_CONF_COMPLETE;
    end else if (t.retryOut) begin
      c = `LCI_CONF_RETRY;
    end else if (!t.noAck) begin
      case (t.ack)
        `LCI_CONF_COMPLETE: c = `LCI_CONF_COMPLETE;
        `LCI_CONF_PENDING: c = `LCI_CONF_PENDING;
        `LCI_CONF_DATAERR: c = `LCI_CONF_DATAERR;
        `LCI_CONF_TYPEERR: c = `LCI_CONF_TYPEERR;
        default: c = `LCI_CONF_NOACK;
      endcase
    end
    return c;
  endfunction : confCode

  function automatic logic hitArea(input logic [11:0] a, input logic [11:0] base,
                                   input int k);
    return a == base + 12'(4 * k);
  endfunction : hitArea

  // ********************
  // state
  // ********************
  lci_pkg::lci_state_type q;
  lci_pkg::lci_state_type d;
  logic [4:0] areaAny;
  logic [4:0][7:0] clrMask;
  logic powerDown;

  always_comb begin
    for (int k = 0; k < 5; k++) begin
      areaAny[k] = |(q.stat[k] & q.ena[k]);
    end
  end
  assign powerDown = q.pdSync[1];

  always_comb begin
    d = q;
    d.pdSync = {q.pdSync[0], linkPowerDownPin};
    d.strapSync = {q.strapSync[0], littleEndianStrapPin};
    d.confValid = 1'b0;
    if (tx.done) begin
      d.confValid = 1'b1;
      d.conf.toResp = tx.fromResp;
      d.conf.label = tx.label;
      d.conf.code = confCode(tx);
    end
    for (int k = 0; k < 5; k++) begin
      clrMask[k] = 8'h00;
      if (bus.wr && hitArea(bus.addr, `LCI_OFS_STAT_BASE, k)) begin
        clrMask[k] = bus.wrData[7:0];
      end
      if (k == `LCI_PWR_AREA && bus.wr && bus.addr == `LCI_OFS_PWR_STAT) begin
        clrMask[k] = bus.wrData[7:0];
      end
      d.stat[k] = (q.stat[k] & ~clrMask[k]) | areaEvent[k];
      if (bus.wr && hitArea(bus.addr, `LCI_OFS_ENA_BASE, k)) begin
        d.ena[k] = bus.wrData[7:0];
      end
    end
    // whole quadlet writes, undefined bits masked
    if (bus.wr && bus.addr == `LCI_OFS_NODE_ID) begin
      d.busNum = bus.wrData[31:22];
      d.nodeNum = bus.wrData[21:16];
    end
    if (bus.wr && bus.addr == `LCI_OFS_LINK_CTRL) begin
      d.ctrl = bus.wrData & `LCI_CTRL_WMASK;
    end
    if (busResetStart) begin
      d.busNum = `LCI_BUS_RESET_VAL;
    end
    if (busResetDone) begin
      d.nodeNum = phyNodeNumber;
      d.ctrl[`LCI_BIT_IDENTITY_VALID] = 1'b1;
    end
    d.irqN = ~(|areaAny);
    // read data for the next cycle
    d.rdData = 32'h0000_0000;
    if (bus.rd) begin
      if (powerDown && bus.addr != `LCI_OFS_PWR_STAT) begin
        d.rdData = `LCI_PD_FILL;
      end else begin
        case (bus.addr)
          `LCI_OFS_NODE_ID: d.rdData = {q.busNum, q.nodeNum, PART_CODE, REV_CODE};
          `LCI_OFS_LINK_CTRL: d.rdData = q.ctrl | (32'(q.strap) << `LCI_BIT_LITTLE_ENDIAN_STRAP);
          `LCI_OFS_PWR_STAT: d.rdData = {24'h00_0000, q.stat[`LCI_PWR_AREA]};
          `LCI_OFS_SUMMARY: d.rdData = {28'h000_0000, areaAny[3:0]};
          default: begin
            for (int k = 0; k < 5; k++) begin
              if (hitArea(bus.addr, `LCI_OFS_STAT_BASE, k)) begin
                d.rdData = {24'h00_0000, q.stat[k]};
              end
              if (hitArea(bus.addr, `LCI_OFS_ENA_BASE, k)) begin
                d.rdData = {24'h00_0000, q.ena[k]};
              end
            end
          end
        endcase
      end
    end
    if (rst) begin
      d.stat = '0;
      d.ena = '0;
      d.busNum = `LCI_BUS_RESET_VAL;
      d.nodeNum = 6'h3F;
      d.ctrl = `LCI_CTRL_RESET;
      d.strap = q.strapSync[1];
      d.irqN = 1'b1;
      d.rdData = 32'h0000_0000;
      d.confValid = 1'b0;
      d.conf = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    q <= d;
  end

  // ********************
  // outputs
  // ********************
  assign rdData = q.rdData;
  assign confValid = q.confValid;
  assign conf = q.conf;
  assign host_interrupt_n = q.irqN;
  assign sourceAddress = {q.busNum, q.nodeNum};
  assign identityValid = q.ctrl[`LCI_BIT_IDENTITY_VALID];
  assign selfIdReceive = q.ctrl[`LCI_BIT_SELFID];
  assign busyPolicy = q.ctrl[29:27];
  assign transmitEnable = q.ctrl[`LCI_BIT_TXEN];
  assign receiveEnable = q.ctrl[`LCI_BIT_RXEN];
  assign littleEndian = q.strap;
  assign byteOrderInvariance = q.strap & q.ctrl[`LCI_BIT_BYTE_ORDER_INVARIANCE];

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_confRoute;
    tx.done |=> confValid && conf.toResp == $past(tx.fromResp);
  endproperty
  a_confRoute: assert property (p_confRoute) else $error("confirmation queue wrong");

  property p_confLabel;
    tx.done |=> conf.label == $past(tx.label);
  endproperty
  a_confLabel: assert property (p_confLabel) else $error("confirmation label wrong");

  property p_confCode;
    tx.done && tx.broadcast |=> conf.code == `LCI_CONF_COMPLETE;
  endproperty
  a_confCode: assert property (p_confCode) else $error("broadcast code wrong");

  property p_irqOn;
    (|areaAny) |=> !host_interrupt_n;
  endproperty
  a_irqOn: assert property (p_irqOn) else $error("interrupt not raised");

  property p_irqOff;
    !(|areaAny) |=> host_interrupt_n;
  endproperty
  a_irqOff: assert property (p_irqOff) else $error("interrupt not released");

  property p_w1c;
    bus.wr && bus.addr == `LCI_OFS_STAT_BASE && bus.wrData[0] && !areaEvent[0][0]
      |=> !q.stat[0][0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_latch;
    q.stat[0][0] && !(bus.wr && bus.addr == `LCI_OFS_STAT_BASE) |=> q.stat[0][0];
  endproperty
  a_latch: assert property (p_latch) else $error("status bit lost");

  property p_busReset;
    busResetStart && !busResetDone |=> sourceAddress[15:6] == `LCI_BUS_RESET_VAL;
  endproperty
  a_busReset: assert property (p_busReset) else $error("bus number not reset");

  property p_nodeLoad;
    busResetDone |=> sourceAddress[5:0] == $past(phyNodeNumber) && identityValid;
  endproperty
  a_nodeLoad: assert property (p_nodeLoad) else $error("node number not loaded");

  property p_pdRead;
    bus.rd && powerDown && bus.addr != `LCI_OFS_PWR_STAT |=> rdData == `LCI_PD_FILL;
  endproperty
  a_pdRead: assert property (p_pdRead) else $error("power-down read leaked");

  property p_pdStatRead;
    bus.rd && bus.addr == `LCI_OFS_PWR_STAT |=> rdData == {24'h00_0000, $past(q.stat[4])};
  endproperty
  a_pdStatRead: assert property (p_pdStatRead) else $error("power status read wrong");

  property p_confOnlyAfterDone;
    !tx.done |=> !confValid;
  endproperty
  a_confOnlyAfterDone: assert property (p_confOnlyAfterDone) else $error("stray confirmation");

  property p_confRetry;
    tx.done && !tx.broadcast && tx.retryOut |=> conf.code == `LCI_CONF_RETRY;
  endproperty
  a_confRetry: assert property (p_confRetry) else $error("retry code wrong");

  property p_confNoAck;
    tx.done && !tx.broadcast && !tx.retryOut && tx.noAck |=> conf.code == `LCI_CONF_NOACK;
  endproperty
  a_confNoAck: assert property (p_confNoAck) else $error("no-ack code wrong");

  property p_summaryRead;
    bus.rd && !powerDown && bus.addr == `LCI_OFS_SUMMARY
      |=> rdData == {28'h000_0000, $past(areaAny[3:0])};
  endproperty
  a_summaryRead: assert property (p_summaryRead) else $error("summary read wrong");

  property p_ctrlWrite;
    bus.wr && bus.addr == `LCI_OFS_LINK_CTRL && !busResetDone
      |=> q.ctrl == ($past(bus.wrData) & `LCI_CTRL_WMASK);
  endproperty
  a_ctrlWrite: assert property (p_ctrlWrite) else $error("control write wrong");

  property p_idRead;
    bus.rd && !powerDown && bus.addr == `LCI_OFS_NODE_ID |=> rdData[15:0] == {PART_CODE, REV_CODE};
  endproperty
  a_idRead: assert property (p_idRead) else $error("identity codes wrong");

  property p_idValidStay;
    !identityValid && !busResetDone && !(bus.wr && bus.addr == `LCI_OFS_LINK_CTRL)
      |=> !identityValid;
  endproperty
  a_idValidStay: assert property (p_idValidStay) else $error("identity valid set early");

  property p_selfId;
    bus.wr && bus.addr == `LCI_OFS_LINK_CTRL |=> selfIdReceive == $past(bus.wrData[30]);
  endproperty
  a_selfId: assert property (p_selfId) else $error("self-id routing wrong");

  property p_busyPolicy;
    bus.wr && bus.addr == `LCI_OFS_LINK_CTRL |=> busyPolicy == $past(bus.wrData[29:27]);
  endproperty
  a_busyPolicy: assert property (p_busyPolicy) else $error("busy policy wrong");

  property p_transmit_enable;
    bus.wr && bus.addr == `LCI_OFS_LINK_CTRL |=> transmitEnable == $past(bus.wrData[26]);
  endproperty
  a_transmit_enable: assert property (p_transmit_enable) else $error("transmit enable wrong");

  property p_receive_enable;
    bus.wr && bus.addr == `LCI_OFS_LINK_CTRL |=> receiveEnable == $past(bus.wrData[25]);
  endproperty
  a_receive_enable: assert property (p_receive_enable) else $error("receive enable wrong");

  property p_invariance;
    !littleEndian |-> !byteOrderInvariance;
  endproperty
  a_invariance: assert property (p_invariance) else $error("invariance outside little-endian");

  property p_strapHold;
    !rst |=> $stable(littleEndian);
  endproperty
  a_strapHold: assert property (p_strapHold) else $error("strap value changed");

  c_conf: cover property (tx.done ##1 confValid);
  c_irq: cover property (host_interrupt_n ##1 !host_interrupt_n);
  c_busReset: cover property (busResetStart ##[1:20] busResetDone);
  c_pdRead: cover property (bus.rd && powerDown);
  c_pwrClear: cover property (bus.wr && bus.addr == `LCI_OFS_PWR_STAT);
endmodule : lci_link_ctrl
`default_nettype wire

// [lci_map.svh]
// register offsets, field positions, reset values of the link control core
// assumes quadlet-wide registers reached over a plain strobe port
`ifndef LCI_MAP_SVH
`define LCI_MAP_SVH
// ********************
// offsets
// ********************
`define LCI_OFS_NODE_ID 12'h000
`define LCI_OFS_LINK_CTRL 12'h004
`define LCI_OFS_PWR_STAT 12'h0B0
`define LCI_OFS_SUMMARY 12'h0BC
`define LCI_OFS_STAT_BASE 12'h0C0
`define LCI_OFS_ENA_BASE 12'h0E0
// ********************
// fields and values
// ********************
`define LCI_BUS_RESET_VAL 10'h3FF
`define LCI_CTRL_RESET 32'h4600_0002
`define LCI_CTRL_WMASK 32'hFEBF_FFFF
`define LCI_BIT_IDENTITY_VALID 31
`define LCI_BIT_SELFID 30
`define LCI_BIT_TXEN 26
`define LCI_BIT_RXEN 25
`define LCI_BIT_BYTE_ORDER_INVARIANCE 23
`define LCI_BIT_LITTLE_ENDIAN_STRAP 22
`define LCI_PD_FILL 32'h0000_0000
`define LCI_PWR_AREA 4
`define LCI_CONF_NOACK 4'h0
`define LCI_CONF_COMPLETE 4'h1
`define LCI_CONF_PENDING 4'h2
`define LCI_CONF_RETRY 4'h4
`define LCI_CONF_DATAERR 4'hD
`define LCI_CONF_TYPEERR 4'hE
`endif

// [lci_pkg.sv]
// types shared by the link control core
// assumes nothing of its surroundings
package lci_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wrData;
    logic wr;
    logic rd;
  } lci_bus_type;

  typedef struct packed {
    logic toResp;
    logic [5:0] label;
    logic [3:0] code;
  } lci_conf_type;

  typedef struct packed {
    logic done;
    logic fromResp;
    logic [5:0] label;
    logic broadcast;
    logic noAck;
    logic retryOut;
    logic [3:0] ack;
  } lci_tx_type;

  typedef struct packed {
    logic [4:0][7:0] stat;
    logic [4:0][7:0] ena;
    logic [9:0] busNum;
    logic [5:0] nodeNum;
    logic [31:0] ctrl;
    logic strap;
    logic [1:0] pdSync;
    logic [1:0] strapSync;
    logic irqN;
    logic [31:0] rdData;
    logic confValid;
    lci_conf_type conf;
  } lci_state_type;
endpackage : lci_pkg

// [tb_lci_link_ctrl.sv]
// self-checking bench of the link control core
// assumes lci_pkg and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_lci_link_ctrl;
  logic clk_sys, rst, confValid, hostIntN, identityValid, selfIdReceive;
  logic busResetStart, busResetDone, linkPowerDownPin, littleEndianStrapPin;
  logic transmitEnable, receiveEnable, littleEndian, byteOrderInvariance;
  lci_pkg::lci_bus_type bus;
  lci_pkg::lci_tx_type tx;
  lci_pkg::lci_conf_type conf;
  logic [31:0] rdData, v, p;
  logic [4:0][7:0] areaEvent;
  logic [5:0] phyNodeNumber;
  logic [15:0] sourceAddress;
  logic [2:0] busyPolicy;
  logic [10:0] cf [8] = '{11'h401, 11'h124, 11'h210, 11'h011, 11'h022, 11'h0DD, 11'h0EE,
    11'h040};
  logic [2:0] pol [4] = '{3'h0, 3'h3, 3'h4, 3'h7};
  int failures = 0;
  int checked = 0;
  lci_link_ctrl lci_link_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdData(rdData),
    .tx(tx), .confValid(confValid), .conf(conf), .areaEvent(areaEvent),
    .busResetStart(busResetStart), .busResetDone(busResetDone), .phyNodeNumber(phyNodeNumber),
    .linkPowerDownPin(linkPowerDownPin), .littleEndianStrapPin(littleEndianStrapPin),
    .host_interrupt_n(hostIntN), .sourceAddress(sourceAddress), .identityValid(identityValid),
    .selfIdReceive(selfIdReceive), .busyPolicy(busyPolicy), .transmitEnable(transmitEnable),
    .receiveEnable(receiveEnable), .littleEndian(littleEndian),
    .byteOrderInvariance(byteOrderInvariance));
  lci_host_model lci_host_model_inst (.clk_sys(clk_sys), .bus(bus), .rdData(rdData));
  // ********************
  // checking and closing
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    #40000;
    failures++;
    $display("Error at %0t ns: watchdog expired", $time);
    complete_run();
  end
  initial begin
    rst = 1'b1;
    tx = '0;
    areaEvent = '0;
    busResetStart = 1'b0;
    busResetDone = 1'b0;
    phyNodeNumber = 6'h15;
    linkPowerDownPin = 1'b0;
    littleEndianStrapPin = 1'b1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    lci_host_model_inst.rd(12'h004, v);
    chk(v, 32'h4640_0002);
    lci_host_model_inst.rd(12'h000, v);
    chk(v, 32'hFFFF_A55A);
    chk(32'(littleEndian), 32'h1);
    $display("reset values done");
    lci_host_model_inst.wr(12'h004, 32'hFFFF_FFFF);
    lci_host_model_inst.rd(12'h004, v);
    chk(v, 32'hFEFF_FFFF);
    chk(32'({identityValid, selfIdReceive, busyPolicy, transmitEnable, receiveEnable,
      byteOrderInvariance}), 32'hFF);
    for (int i = 0; i < 4; i++) begin
      lci_host_model_inst.wr(12'h004, {2'h0, pol[i], 1'b1, 26'h000_0000});
      lci_host_model_inst.rd(12'h004, v);
      chk(v, {2'h0, pol[i], 5'h11, 22'h00_0000});
      chk(32'({busyPolicy, transmitEnable, receiveEnable, selfIdReceive}), (32'(pol[i]) << 3) | 32'h4);
    end
    $display("control register done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      tx <= {1'b1, i[0], 6'(i + 5), cf[i][10:4]};
      @(posedge clk_sys);
      tx.done <= 1'b0;
      #1 chk(32'({confValid, conf}), {20'h0, 1'b1, i[0], 6'(i + 5), cf[i][3:0]});
    end
    @(posedge clk_sys);
    #1 chk(32'(confValid), 32'h0);
    $display("confirmations done");
    for (int k = 0; k < 5; k++) begin
      lci_host_model_inst.wr(12'(12'h0E0 + 4 * k), 32'h1);
      @(posedge clk_sys);
      areaEvent[k] <= 8'h03;
      @(posedge clk_sys);
      areaEvent <= '0;
      @(posedge clk_sys);
      #1 chk(32'(hostIntN), 32'h0);
      lci_host_model_inst.poll(p, v);
      chk(p, (k == 4) ? 32'h3 : 32'h0);
      chk(v, (k < 4) ? (32'h1 << k) : 32'h0);
      lci_host_model_inst.wr(12'(12'h0C0 + 4 * k), 32'h0);
      lci_host_model_inst.rd(12'(12'h0C0 + 4 * k), v);
      chk(v, 32'h3);
      lci_host_model_inst.wr(12'(12'h0C0 + 4 * k), 32'h1);
      repeat (2) @(posedge clk_sys);
      #1 chk(32'(hostIntN), 32'h1);
      lci_host_model_inst.poll(p, v);
      chk(v, 32'h0);
      lci_host_model_inst.wr(12'(12'h0C0 + 4 * k), 32'h2);
      lci_host_model_inst.wr(12'(12'h0E0 + 4 * k), 32'h0);
    end
    $display("interrupts done");
    @(posedge clk_sys);
    linkPowerDownPin <= 1'b1;
    areaEvent[4] <= 8'h04;
    @(posedge clk_sys);
    areaEvent <= '0;
    repeat (2) @(posedge clk_sys);
    lci_host_model_inst.poll(p, v);
    chk(p, 32'h4);
    chk(v, 32'h0);
    lci_host_model_inst.rd(12'h004, v);
    chk(v, 32'h0000_0000);
    lci_host_model_inst.wr(12'h0B0, 32'h4);
    linkPowerDownPin <= 1'b0;
    $display("power down done");
    lci_host_model_inst.wr(12'h000, 32'h1234_5678);
    lci_host_model_inst.rd(12'h000, v);
    chk(v, 32'h1234_A55A);
    chk(32'(sourceAddress), 32'h1234);
    @(posedge clk_sys);
    busResetStart <= 1'b1;
    @(posedge clk_sys);
    busResetStart <= 1'b0;
    lci_host_model_inst.rd(12'h000, v);
    chk(v, 32'hFFF4_A55A);
    @(posedge clk_sys);
    busResetDone <= 1'b1;
    @(posedge clk_sys);
    busResetDone <= 1'b0;
    #1 chk(32'({identityValid, sourceAddress}), 32'h1_FFD5);
    $display("bus reset done");
    complete_run();
  end
endmodule : tb_lci_link_ctrl
`default_nettype wire
